// ==== common/sdc_pkg.sv ====
package sdc_pkg;

	// ========================================================
	// Array organisation
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROWS = 8192;
	localparam int ROW_W = 13;
	localparam int ADDR_W = 13;
	localparam int COLS_X4 = 2048;
	localparam int COLS_X8 = 1024;
	localparam int COLS_X16 = 512;
	localparam int COL_W = 11;
	localparam int LEN_W = 12;
	localparam int AP_BIT = 10;

	typedef enum {VAR_X4, VAR_X8, VAR_X16} sdc_variant_e;
	localparam sdc_variant_e VARIANT = VAR_X8;
	localparam int DATA_W = 8;
	localparam logic [LEN_W-1:0] PAGE_WORDS = (VARIANT == VAR_X4) ? LEN_W'(COLS_X4) :
		(VARIANT == VAR_X8) ? LEN_W'(COLS_X8) : LEN_W'(COLS_X16);

	// ========================================================
	// Burst length codes
	localparam logic [2:0] LEN_CODE_1 = 3'h0;
	localparam logic [2:0] LEN_CODE_2 = 3'h1;
	localparam logic [2:0] LEN_CODE_4 = 3'h2;
	localparam logic [2:0] LEN_CODE_8 = 3'h3;
	localparam logic [2:0] LEN_CODE_PAGE = 3'h7;

	// ========================================================
	// Pin sampling vector layout
	localparam int PIN_W = 29;
	localparam int PIN_CKE = 28;
	localparam int PIN_CS = 27;
	localparam int PIN_RAS = 26;
	localparam int PIN_CAS = 25;
	localparam int PIN_WE = 24;
	localparam int PIN_BA = 22;
	localparam int PIN_ADDR = 9;
	localparam int PIN_DQM = 8;
	localparam int PIN_DQ = 0;
	localparam logic [PIN_W-1:0] PIN_RST = 29'h0F000000;

	// ========================================================
	// Backing store
	localparam int MEM_COL_W = 8;
	localparam int MEM_AW = BANK_W + MEM_COL_W;
	localparam int MEM_WORDS = 1 << MEM_AW;

	typedef enum {
		CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
		CMD_TERM, CMD_PRECHARGE, CMD_REFRESH, CMD_LOAD_MODE
	} sdc_cmd_e;

	typedef enum {PW_RUN, PW_PRE_PD, PW_ACT_PD, PW_SUSPEND} sdc_power_e;

	function automatic sdc_cmd_e decode_cmd(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		if (cs_n)
			return CMD_INHIBIT;
		case ({ras_n, cas_n, we_n})
			3'h7: return CMD_NOP;
			3'h3: return CMD_ACTIVE;
			3'h5: return CMD_READ;
			3'h4: return CMD_WRITE;
			3'h6: return CMD_TERM;
			3'h2: return CMD_PRECHARGE;
			3'h1: return CMD_REFRESH;
			default: return CMD_LOAD_MODE;
		endcase
	endfunction : decode_cmd

	function automatic logic [COL_W-1:0] col_from_addr(input logic [ADDR_W-1:0] a);
		case (VARIANT)
			VAR_X4: return {a[11], a[9:0]};
			VAR_X8: return {1'b0, a[9:0]};
			default: return {2'h0, a[8:0]};
		endcase
	endfunction : col_from_addr

	function automatic logic [LEN_W-1:0] burst_words(input logic [2:0] code);
		case (code)
			LEN_CODE_1: return 12'h001;
			LEN_CODE_2: return 12'h002;
			LEN_CODE_4: return 12'h004;
			LEN_CODE_8: return 12'h008;
			LEN_CODE_PAGE: return PAGE_WORDS;
			default: return 12'h001;
		endcase
	endfunction : burst_words

	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] cnt, input logic [LEN_W-1:0] len, input logic ilv);
		logic [COL_W-1:0] mask;
		logic [COL_W-1:0] off;
		mask = COL_W'(len - LEN_W'(1));
		off = ilv ? (start ^ cnt) : COL_W'(start + cnt);
		return (start & ~mask) | (off & mask);
	endfunction : burst_col

endpackage : sdc_pkg

// ==== common/sdc_mem_if.sv ====
`timescale 1ns/1ps
interface sdc_mem_if import sdc_pkg::*; ();
	logic we;
	logic [MEM_AW-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic re;
	logic [MEM_AW-1:0] raddr;
	logic [DATA_W-1:0] rdata;

	modport ctrl(output we, output waddr, output wdata, output re, output raddr, input rdata);
	modport store(input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface : sdc_mem_if

// ==== logic/sdc_mem.sv ====
`timescale 1ns/1ps
module sdc_mem
	import sdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	sdc_mem_if.store bus
);
	logic [DATA_W-1:0] cells [MEM_WORDS];

	always_ff @(posedge ref_clk) begin
		if (bus.we)
			cells[bus.waddr] <= bus.wdata;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			bus.rdata <= '0;
		else if (bus.re)
			bus.rdata <= cells[bus.raddr];
	end
endmodule : sdc_mem

// ==== logic/sdc_command_if.sv ====
`timescale 1ns/1ps
module sdc_command_if
	import sdc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic dqm,
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic [2:0] burst_len_cfg,
	input wire logic burst_interleave,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	output logic [BANKS-1:0] bank_open,
	output logic burst_active,
	output sdc_power_e power_state
);
	// ========================================================
	// Pin sampling
	logic [PIN_W-1:0] pins_meta;
	logic [PIN_W-1:0] pins_sync;
	logic cke_s;
	logic cs_s;
	logic ras_s;
	logic cas_s;
	logic we_s;
	logic dqm_s;
	logic [BANK_W-1:0] ba_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] dq_s;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pins_meta <= PIN_RST;
			pins_sync <= PIN_RST;
		end else begin
			pins_meta <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_in};
			pins_sync <= pins_meta;
		end
	end

	assign cke_s = pins_sync[PIN_CKE];
	assign cs_s = pins_sync[PIN_CS];
	assign ras_s = pins_sync[PIN_RAS];
	assign cas_s = pins_sync[PIN_CAS];
	assign we_s = pins_sync[PIN_WE];
	assign ba_s = pins_sync[PIN_BA +: BANK_W];
	assign addr_s = pins_sync[PIN_ADDR +: ADDR_W];
	assign dqm_s = pins_sync[PIN_DQM];
	assign dq_s = pins_sync[PIN_DQ +: DATA_W];

	// ========================================================
	// State
	logic [BANKS-1:0] row_open;
	logic [ROW_W-1:0] row_addr [BANKS];
	logic burst_write;
	logic [BANK_W-1:0] burst_bank;
	logic [COL_W-1:0] burst_start;
	logic [COL_W-1:0] burst_cnt;
	logic [LEN_W-1:0] burst_len;
	logic burst_ilv;
	logic burst_page;
	logic burst_ap;
	logic rd_v1;
	logic dqm_d1;

	// ========================================================
	// Command decode and column generation
	sdc_cmd_e cmd;
	logic act;
	logic rw_now;
	logic term_now;
	logic cont;
	logic burst_last;
	logic cfg_page;
	logic [LEN_W-1:0] cfg_len;
	logic [BANK_W-1:0] cur_bank;
	logic [COL_W-1:0] cur_col;
	logic cur_write;
	logic rd_access;
	logic wr_access;
	logic ap_close;

	always_comb begin
		act = cke_s;
		cmd = decode_cmd(cs_s, ras_s, cas_s, we_s);
		cfg_len = burst_words(burst_len_cfg);
		cfg_page = burst_len_cfg == LEN_CODE_PAGE;
		rw_now = act && (cmd == CMD_READ || cmd == CMD_WRITE) && row_open[ba_s];
		term_now = act && cmd == CMD_TERM;
		burst_last = !burst_page && burst_cnt == COL_W'(burst_len - LEN_W'(1));
		cont = act && burst_active && !rw_now && !term_now;
		if (rw_now) begin
			cur_bank = ba_s;
			cur_col = col_from_addr(addr_s);
			cur_write = cmd == CMD_WRITE;
		end else begin
			cur_bank = burst_bank;
			cur_col = burst_col(burst_start, burst_cnt, burst_len, burst_ilv);
			cur_write = burst_write;
		end
		rd_access = (rw_now || cont) && !cur_write;
		wr_access = (rw_now || cont) && cur_write;
		ap_close = (rw_now && addr_s[AP_BIT] && cfg_len == LEN_W'(1))
			|| (cont && burst_last && burst_ap);
	end

	// ========================================================
	// Burst sequencer
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			burst_active <= 1'b0;
			burst_write <= 1'b0;
			burst_bank <= '0;
			burst_start <= '0;
			burst_cnt <= '0;
			burst_len <= LEN_W'(1);
			burst_ilv <= 1'b0;
			burst_page <= 1'b0;
			burst_ap <= 1'b0;
		end else if (rw_now) begin
			burst_active <= cfg_len != LEN_W'(1);
			burst_write <= cmd == CMD_WRITE;
			burst_bank <= ba_s;
			burst_start <= col_from_addr(addr_s);
			burst_cnt <= COL_W'(1);
			burst_len <= cfg_len;
			burst_ilv <= burst_interleave && !cfg_page;
			burst_page <= cfg_page;
			burst_ap <= addr_s[AP_BIT] && !cfg_page;
		end else if (term_now) begin
			burst_active <= 1'b0;
		end else if (cont) begin
			burst_cnt <= burst_cnt + COL_W'(1);
			if (burst_last)
				burst_active <= 1'b0;
		end
	end

	// ========================================================
	// Bank rows
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			row_open <= '0;
			for (int b = 0; b < BANKS; b++)
				row_addr[b] <= '0;
		end else if (act) begin
			if (ap_close)
				row_open[cur_bank] <= 1'b0;
			if (cmd == CMD_ACTIVE) begin
				row_open[ba_s] <= 1'b1;
				row_addr[ba_s] <= addr_s;
			end else if (cmd == CMD_PRECHARGE) begin
				if (addr_s[AP_BIT])
					row_open <= '0;
				else
					row_open[ba_s] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			bank_open <= '0;
		else
			bank_open <= row_open;
	end

	// ========================================================
	// Power state
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			power_state <= PW_PRE_PD;
		else if (cke_s)
			power_state <= PW_RUN;
		else if (burst_active)
			power_state <= PW_SUSPEND;
		else if (row_open != '0)
			power_state <= PW_ACT_PD;
		else
			power_state <= PW_PRE_PD;
	end

	// ========================================================
	// Array access
	sdc_mem_if mem_bus();

	assign mem_bus.we = act && wr_access && !dqm_s;
	assign mem_bus.waddr = {cur_bank, cur_col[MEM_COL_W-1:0]};
	assign mem_bus.wdata = dq_s;
	assign mem_bus.re = act && rd_access;
	assign mem_bus.raddr = {cur_bank, cur_col[MEM_COL_W-1:0]};

	sdc_mem u_mem (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.bus(mem_bus.store)
	);

	// ========================================================
	// Read output pipeline
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_v1 <= 1'b0;
			dqm_d1 <= 1'b0;
			dq_out <= '0;
			dq_oe_n <= 1'b1;
		end else if (act) begin
			rd_v1 <= rd_access;
			dqm_d1 <= dqm_s;
			dq_out <= mem_bus.rdata;
			dq_oe_n <= !(rd_v1 && !dqm_d1);
		end
	end

	// ========================================================
	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_rd_masked;
		act && rd_access && dqm_s ##1 act;
	endsequence
	sequence s_rd_open;
		act && rd_access && !dqm_s ##1 act;
	endsequence
	sequence s_ap_end;
		cont && burst_last && burst_ap;
	endsequence

	property p_dqm_read_hiz;
		s_rd_masked |=> dq_oe_n;
	endproperty
	a_dqm_read_hiz: assert property (p_dqm_read_hiz) else $error("masked read drove bus");

	property p_read_drives;
		s_rd_open |=> !dq_oe_n;
	endproperty
	a_read_drives: assert property (p_read_drives) else $error("read data not driven");

	property p_freeze;
		!cke_s |=> $stable(burst_cnt) && $stable(dq_out) && $stable(row_open);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with clock gated");

	property p_suspend;
		!cke_s && burst_active |=> power_state == PW_SUSPEND;
	endproperty
	a_suspend: assert property (p_suspend) else $error("no suspend during burst");

	property p_idle_pd;
		!cke_s && !burst_active && row_open == '0 |=> power_state == PW_PRE_PD;
	endproperty
	a_idle_pd: assert property (p_idle_pd) else $error("no precharge power-down");

	property p_wake;
		cke_s |=> power_state == PW_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("low-power state not exited");

	property p_activate;
		act && cmd == CMD_ACTIVE |=> row_open[$past(ba_s)] && row_addr[$past(ba_s)] == $past(addr_s);
	endproperty
	a_activate: assert property (p_activate) else $error("row not opened");

	property p_pre_all;
		act && cmd == CMD_PRECHARGE && addr_s[AP_BIT] |=> row_open == '0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("banks left open");

	property p_auto_pre;
		s_ap_end |=> !row_open[$past(burst_bank)];
	endproperty
	a_auto_pre: assert property (p_auto_pre) else $error("auto precharge missed");

	property p_cs_burst;
		act && cs_s && burst_active && !burst_last
			|=> burst_active && burst_cnt == COL_W'($past(burst_cnt) + 1);
	endproperty
	a_cs_burst: assert property (p_cs_burst) else $error("burst stalled by chip select");

	property p_hidden_pre;
		act && burst_active && !burst_last && cmd == CMD_PRECHARGE && !addr_s[AP_BIT]
			&& ba_s != burst_bank |=> burst_active;
	endproperty
	a_hidden_pre: assert property (p_hidden_pre) else $error("precharge broke burst");

endmodule : sdc_command_if

// ==== test/sdc_host.sv ====
`timescale 1ns/1ps
module sdc_host
	import sdc_pkg::*;
(
	input wire logic ref_clk,
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [BANK_W-1:0] ba,
	output logic [ADDR_W-1:0] addr,
	output logic dqm,
	output logic [DATA_W-1:0] dq_in
);
	// ==========
	// Pin state
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		ba = 2'h0;
		addr = 13'h0000;
		dqm = 1'b0;
		dq_in = 8'h00;
	end

	// ==========
	// One command cycle
	task automatic cmd(input logic c, input logic [2:0] op, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a, input logic m, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		cs_n <= c;
		{ras_n, cas_n, we_n} <= op;
		ba <= b;
		addr <= a;
		dqm <= m;
		dq_in <= d;
	endtask : cmd

	// Released lines do not keep their last value
	task automatic nop();
		cmd(1'b0, 3'h7, ~ba, ~addr, 1'b0, ~dq_in);
	endtask : nop

	// Power-down and suspend only, never self refresh
	task automatic gate(input logic v);
		@(posedge ref_clk);
		cke <= v;
		{ras_n, cas_n, we_n} <= 3'h7;
	endtask : gate
endmodule : sdc_host

// ==== test/sdc_command_if_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module sdc_command_if_tb
	import sdc_pkg::*;
();
	localparam logic [2:0] OP_ACT = 3'h3;
	localparam logic [2:0] OP_RD = 3'h5;
	localparam logic [2:0] OP_WR = 3'h4;
	localparam logic [2:0] OP_TERM = 3'h6;
	localparam logic [2:0] OP_PRE = 3'h2;
	localparam logic [2:0] OP_NOP = 3'h7;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic cke, cs_n, ras_n, cas_n, we_n, dqm, burst_interleave, dq_oe_n, burst_active;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dq_in, dq_out;
	logic [2:0] burst_len_cfg;
	logic [BANKS-1:0] bank_open;
	sdc_power_e power_state;
	int n_mismatch = 0;
	int n_tests = 0;

	always #20 ref_clk = ~ref_clk;

	sdc_host sdc_host_i (
		.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in)
	);

	sdc_command_if sdc_command_if_i (
		.ref_clk(ref_clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
		.burst_len_cfg(burst_len_cfg), .burst_interleave(burst_interleave),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .bank_open(bank_open),
		.burst_active(burst_active), .power_state(power_state)
	);

	// ==========
	// Helpers
	task automatic end_sim();
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic op(input logic [2:0] o, input logic [1:0] b, input logic [12:0] a,
		input logic [7:0] d);
		sdc_host_i.cmd(1'b0, o, b, a, 1'b0, d);
	endtask : op

	task automatic idle(input int n);
		repeat (n) sdc_host_i.nop();
	endtask : idle

	// One read word slot; first slot is the fourth edge after the command
	task automatic word(input logic oe_n, input logic [7:0] d);
		sdc_host_i.nop();
		#1;
		`CHK(dq_oe_n, oe_n)
		if (!oe_n)
			`CHK(dq_out, d)
	endtask : word

	task automatic wait_ps(input sdc_power_e p);
		for (int i = 0; i < 12 && power_state !== p; i++)
			@(posedge ref_clk);
		#1;
		`CHK(power_state, p)
	endtask : wait_ps

	// ==========
	// Scenarios
	task automatic t_burst();
		burst_len_cfg <= LEN_CODE_4;
		burst_interleave <= 1'b1;
		op(OP_ACT, 2'h1, 13'h1ABC, 8'h00);
		idle(1);
		op(OP_WR, 2'h1, 13'h0009, 8'h11);
		op(OP_NOP, 2'h1, 13'h0000, 8'h22);
		op(OP_NOP, 2'h1, 13'h0000, 8'h33);
		op(OP_NOP, 2'h1, 13'h0000, 8'h44);
		idle(3);
		burst_interleave <= 1'b0;
		#1;
		`CHK(bank_open, 4'h2)
		op(OP_RD, 2'h1, 13'h0008, 8'h00);
		idle(3);
		word(1'b0, 8'h22);
		word(1'b0, 8'h11);
		word(1'b0, 8'h44);
		word(1'b0, 8'h33);
		word(1'b1, 8'h00);
	endtask : t_burst

	task automatic t_mask();
		op(OP_WR, 2'h1, 13'h0008, 8'h55);
		sdc_host_i.cmd(1'b1, OP_NOP, 2'h1, 13'h0000, 1'b1, 8'h66);
		op(OP_NOP, 2'h1, 13'h0000, 8'h77);
		op(OP_NOP, 2'h1, 13'h0000, 8'h88);
		idle(2);
		sdc_host_i.cmd(1'b0, OP_RD, 2'h1, 13'h0008, 1'b1, 8'h00);
		sdc_host_i.cmd(1'b1, OP_RD, 2'h1, 13'h000A, 1'b0, 8'h00);
		sdc_host_i.cmd(1'b1, OP_ACT, 2'h2, 13'h0005, 1'b0, 8'h00);
		idle(1);
		word(1'b1, 8'h00);
		word(1'b0, 8'h11);
		word(1'b0, 8'h77);
		word(1'b0, 8'h88);
		`CHK(bank_open, 4'h2)
	endtask : t_mask

	task automatic t_interleave();
		op(OP_ACT, 2'h2, 13'h0005, 8'h00);
		idle(1);
		op(OP_RD, 2'h1, 13'h0008, 8'h00);
		op(OP_RD, 2'h1, 13'h000A, 8'h00);
		op(OP_PRE, 2'h2, 13'h0000, 8'h00);
		idle(1);
		word(1'b0, 8'h55);
		word(1'b0, 8'h77);
		word(1'b0, 8'h88);
		word(1'b0, 8'h55);
		word(1'b0, 8'h11);
		`CHK(bank_open, 4'h2)
	endtask : t_interleave

	task automatic t_autopre();
		burst_len_cfg <= LEN_CODE_1;
		op(OP_RD, 2'h1, 13'h0409, 8'h00);
		idle(3);
		word(1'b0, 8'h11);
		word(1'b1, 8'h00);
		idle(2);
		#1;
		`CHK(bank_open, 4'h0)
		op(OP_ACT, 2'h0, 13'h0000, 8'h00);
		op(OP_ACT, 2'h3, 13'h1FFF, 8'h00);
		idle(4);
		#1;
		`CHK(bank_open, 4'h9)
		op(OP_PRE, 2'h0, 13'h0400, 8'h00);
		idle(4);
		#1;
		`CHK(bank_open, 4'h0)
	endtask : t_autopre

	task automatic t_power();
		logic [7:0] held;
		sdc_host_i.gate(1'b0);
		wait_ps(PW_PRE_PD);
		sdc_host_i.gate(1'b1);
		wait_ps(PW_RUN);
		burst_len_cfg <= LEN_CODE_PAGE;
		op(OP_ACT, 2'h1, 13'h1ABC, 8'h00);
		sdc_host_i.gate(1'b0);
		wait_ps(PW_ACT_PD);
		sdc_host_i.gate(1'b1);
		wait_ps(PW_RUN);
		op(OP_RD, 2'h1, 13'h0008, 8'h00);
		idle(3);
		word(1'b0, 8'h55);
		sdc_host_i.gate(1'b0);
		wait_ps(PW_SUSPEND);
		held = dq_out;
		idle(4);
		#1;
		`CHK(dq_out, held)
		`CHK(burst_active, 1'b1)
		sdc_host_i.gate(1'b1);
		op(OP_TERM, 2'h1, 13'h0000, 8'h00);
		idle(6);
		#1;
		`CHK(burst_active, 1'b0)
		`CHK(dq_oe_n, 1'b1)
	endtask : t_power

	// Eight-word write, then a two-word read that closes the row itself
	task automatic t_lengths();
		burst_len_cfg <= LEN_CODE_8;
		op(OP_WR, 2'h1, 13'h0010, 8'hA0);
		for (int i = 1; i < 8; i++)
			op(OP_NOP, 2'h1, 13'h0000, 8'hA0 | 8'(i));
		burst_len_cfg <= LEN_CODE_2;
		op(OP_RD, 2'h1, 13'h0416, 8'h00);
		idle(3);
		word(1'b0, 8'hA6);
		word(1'b0, 8'hA7);
		word(1'b1, 8'h00);
		`CHK(bank_open, 4'h0)
	endtask : t_lengths

	// Reset in mid-run closes every row; a read to a closed bank is refused
	task automatic t_reset();
		op(OP_ACT, 2'h2, 13'h0007, 8'h00);
		idle(4);
		#1;
		`CHK(bank_open, 4'h4)
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK(bank_open, 4'h0)
		`CHK(power_state, PW_PRE_PD)
		`CHK(dq_oe_n, 1'b1)
		`CHK(burst_active, 1'b0)
		@(posedge ref_clk);
		resetn <= 1'b1;
		wait_ps(PW_RUN);
		op(OP_RD, 2'h2, 13'h0008, 8'h00);
		idle(3);
		word(1'b1, 8'h00);
		`CHK(burst_active, 1'b0)
	endtask : t_reset

	// ==========
	// Main sequence and watchdog
	initial begin
		burst_len_cfg = LEN_CODE_4;
		burst_interleave = 1'b0;
		repeat (8) @(posedge ref_clk);
		`CHK(power_state, PW_PRE_PD)
		`CHK(dq_oe_n, 1'b1)
		resetn <= 1'b1;
		wait_ps(PW_RUN);
		t_burst();
		t_mask();
		t_interleave();
		t_autopre();
		t_power();
		t_lengths();
		t_reset();
		end_sim();
	end

	initial begin
		repeat (3000) @(posedge ref_clk);
		n_mismatch++;
		end_sim();
	end
endmodule : sdc_command_if_tb
